// ### pkg/pbs_consts.svh
// Constants for the pipelined burst SRAM port
`ifndef PBS_CONSTS_SVH
`define PBS_CONSTS_SVH
`define PBS_LANES       4
`define PBS_LANE_W      9
`define PBS_DATA_W      36
`define PBS_ADDR_W      18
`define PBS_MEM_WORDS   256
`define PBS_MEM_AW      8
`define PBS_PIPE_DEPTH  2
`define PBS_SYNC_STAGES 3
`endif

// ### pkg/pbs_pkg.sv
// Types for the pipelined burst SRAM port
package pbs_pkg;
   typedef enum logic [1:0] {
      PBS_IDLE,
      PBS_READ,
      PBS_WRITE
   } pbs_op_t;
endpackage

// ### design/pbs_sync3.sv
// Three-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pbs_sync3 (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic din,
   output var  logic dout
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic o_q;
   logic o_d;

   always_comb begin
      o_d = o_q;
      if (s2_q == s3_q) begin
         o_d = s3_q;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         o_q  <= 1'b0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         o_q  <= o_d;
      end
   end

   assign dout = o_q;
endmodule // pbs_sync3
`default_nettype wire

// ### design/pbs_sram_port.sv
// Pipelined zero-turnaround burst SRAM port with interleaved or linear bursts
`timescale 1ns/1ps
`default_nettype none
`include "pbs_consts.svh"

// Operation
// - Selected load with read select high starts read; data out two cycles later.
// - Selected load with read select low starts write; data taken two cycles later.
// - Continue cycles keep direction latched at burst start.
// - Two-bit burst counter advances each continue after a selected load, wraps every fourth cycle.
// - Interleaved order: start bits XOR step count.
// - Linear order: start bits plus step modulo four.
// - Each lane written only when its active-low enable is low.
// - Any combination of lanes may be written together.
// - Lanes two and three always exist; the port is always 36 bits wide.
// - All lane enables high is abort write: nothing stored, bus released.
// - Output enable high makes dummy read: bus released, counter advances.
// - Load while deselected releases bus two cycles later; step continues deselect.
// - Clock enable high ignores the edge; data_out holds, data_oe still follows output enable.
// - Drivers turn off by themselves during writes.
// - Data outputs released from power-up until a read is issued.
// - Step cycles ignore external address and read select.
// - Selected only when both low enables low and high enable high.
module pbs_sram_port
   import pbs_pkg::*;
(
   input  wire logic                      clk,
   input  wire logic                      arst_n,
   input  wire logic                      clk_en_n,
   input  wire logic                      chip_select_n,
   input  wire logic                      chip_select2_n,
   input  wire logic                      chip_select_high,
   input  wire logic                      burst_step_or_load,
   input  wire logic                      read_not_write,
   input  wire logic [`PBS_ADDR_W-1:0]    addr,
   input  wire logic [`PBS_LANES-1:0]     lane_write_n,
   input  wire logic                      out_enable_n,
   input  wire logic                      burst_order,
   input  wire logic                      snooze_request,
   input  wire logic [`PBS_DATA_W-1:0]    data_in,
   output var  logic [`PBS_DATA_W-1:0]    data_out,
   output var  logic [`PBS_DATA_W-1:0]    data_oe,
   output var  logic                      snoozing
);
   ////////////////////////////////////////////////////////////////////////////
   // Asynchronous pins
   logic oe_n_s;
   logic snooze_s;
   logic order_s;

   pbs_sync3 u_sync_oe (
      .clk    (clk),
      .arst_n (arst_n),
      .din    (out_enable_n),
      .dout   (oe_n_s)
   );
   pbs_sync3 u_sync_snooze (
      .clk    (clk),
      .arst_n (arst_n),
      .din    (snooze_request),
      .dout   (snooze_s)
   );
   pbs_sync3 u_sync_mode (
      .clk    (clk),
      .arst_n (arst_n),
      .din    (~burst_order),
      .dout   (order_s)
   );
   logic interleaved;
   assign interleaved = ~order_s;
   assign snoozing    = snooze_s;

   ////////////////////////////////////////////////////////////////////////////
   // Cycle decode and burst state
   logic                   edge_en;
   logic                   selected;
   logic                   load;
   pbs_op_t                op_q;
   pbs_op_t                op_d;
   logic [`PBS_ADDR_W-1:0] base_q;
   logic [`PBS_ADDR_W-1:0] base_d;
   logic [1:0]             step_q;
   logic [1:0]             step_d;
   logic [1:0]             low_bits;
   logic [`PBS_ADDR_W-1:0] cur_addr;
   pbs_op_t                cyc_op;

   assign edge_en  = ~clk_en_n & ~snooze_s;
   assign selected = ~chip_select_n & ~chip_select2_n & chip_select_high;
   assign load     = ~burst_step_or_load;

   always_comb begin
      op_d   = op_q;
      base_d = base_q;
      step_d = step_q;
      cyc_op = PBS_IDLE;
      if (edge_en) begin
         if (load) begin
            step_d = 2'h0;
            base_d = addr;
            if (!selected) begin
               op_d = PBS_IDLE;
            end else if (read_not_write) begin
               op_d = PBS_READ;
            end else begin
               op_d = PBS_WRITE;
            end
            cyc_op = op_d;
         end else begin
            // Step ignores address and direction pins
            cyc_op = op_q;
            if (op_q != PBS_IDLE) begin
               step_d = step_q + 2'h1;
            end
         end
      end
   end

   // Address of the cycle being issued
   always_comb begin
      logic [1:0] st;
      logic [1:0] start;
      st    = load ? 2'h0 : step_d;
      start = load ? addr[1:0] : base_q[1:0];
      if (interleaved) begin
         low_bits = start ^ st;
      end else begin
         low_bits = start + st;
      end
      cur_addr = {(load ? addr[`PBS_ADDR_W-1:2] : base_q[`PBS_ADDR_W-1:2]), low_bits};
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         op_q   <= PBS_IDLE;
         base_q <= '0;
         step_q <= 2'h0;
      end else begin
         op_q   <= op_d;
         base_q <= base_d;
         step_q <= step_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Two-stage pipeline to the data phase
   pbs_op_t                p_op_q   [`PBS_PIPE_DEPTH];
   pbs_op_t                p_op_d   [`PBS_PIPE_DEPTH];
   logic [`PBS_MEM_AW-1:0] p_addr_q [`PBS_PIPE_DEPTH];
   logic [`PBS_MEM_AW-1:0] p_addr_d [`PBS_PIPE_DEPTH];
   logic [`PBS_LANES-1:0]  p_we_q   [`PBS_PIPE_DEPTH];
   logic [`PBS_LANES-1:0]  p_we_d   [`PBS_PIPE_DEPTH];

   always_comb begin
      for (int i = 0; i < `PBS_PIPE_DEPTH; i++) begin
         p_op_d[i]   = p_op_q[i];
         p_addr_d[i] = p_addr_q[i];
         p_we_d[i]   = p_we_q[i];
      end
      if (edge_en) begin
         p_op_d[0]   = cyc_op;
         p_addr_d[0] = cur_addr[`PBS_MEM_AW-1:0];
         p_we_d[0]   = ~lane_write_n;
         p_op_d[1]   = p_op_q[0];
         p_addr_d[1] = p_addr_q[0];
         p_we_d[1]   = p_we_q[0];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < `PBS_PIPE_DEPTH; i++) begin
            p_op_q[i]   <= PBS_IDLE;
            p_addr_q[i] <= '0;
            p_we_q[i]   <= '0;
         end
      end else begin
         for (int i = 0; i < `PBS_PIPE_DEPTH; i++) begin
            p_op_q[i]   <= p_op_d[i];
            p_addr_q[i] <= p_addr_d[i];
            p_we_q[i]   <= p_we_d[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Storage and data phase
   logic [`PBS_DATA_W-1:0] mem_q [`PBS_MEM_WORDS];
   logic [`PBS_DATA_W-1:0] mem_d [`PBS_MEM_WORDS];
   logic [`PBS_DATA_W-1:0] dout_q;
   logic [`PBS_DATA_W-1:0] dout_d;
   logic                   rd_q;
   logic                   rd_d;
   logic                   wr_phase;
   logic                   rd_phase;

   assign wr_phase = edge_en && (p_op_q[1] == PBS_WRITE);
   assign rd_phase = edge_en && (p_op_q[1] == PBS_READ);

   always_comb begin
      for (int w = 0; w < `PBS_MEM_WORDS; w++) begin
         mem_d[w] = mem_q[w];
      end
      dout_d = dout_q;
      rd_d   = rd_q;
      if (edge_en) begin
         rd_d = rd_phase;
      end
      if (wr_phase) begin
         // Abort write when no lane enabled
         for (int l = 0; l < `PBS_LANES; l++) begin
            if (p_we_q[1][l]) begin
               mem_d[p_addr_q[1]][l*`PBS_LANE_W +: `PBS_LANE_W] = data_in[l*`PBS_LANE_W +: `PBS_LANE_W];
            end
         end
      end
      if (rd_phase) begin
         dout_d = mem_q[p_addr_q[1]];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int w = 0; w < `PBS_MEM_WORDS; w++) begin
            mem_q[w] <= '0;
         end
         dout_q <= '0;
         rd_q   <= 1'b0;
      end else begin
         for (int w = 0; w < `PBS_MEM_WORDS; w++) begin
            mem_q[w] <= mem_d[w];
         end
         dout_q <= dout_d;
         rd_q   <= rd_d;
      end
   end

   assign data_out = dout_q;
   assign data_oe  = {`PBS_DATA_W{rd_q & ~oe_n_s}};

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_read_two_cycles: assert property (@(posedge clk) disable iff (!arst_n)
      (edge_en && load && selected && read_not_write) ##1 edge_en [*1] ##1 edge_en
      |=> rd_q)
      else $error("read data not driven two cycles after load");
   a_write_no_drive: assert property (@(posedge clk) disable iff (!arst_n)
      (p_op_q[1] == PBS_WRITE && edge_en) |=> data_oe == '0)
      else $error("drivers on during write");
   a_deselect_release: assert property (@(posedge clk) disable iff (!arst_n)
      (edge_en && load && !selected) ##1 edge_en ##1 edge_en |=> !rd_q)
      else $error("bus not released after deselect");
   a_hold_edge: assert property (@(posedge clk) disable iff (!arst_n)
      !edge_en |=> $stable(dout_q) && $stable(rd_q))
      else $error("output changed on ignored edge");
   a_step_count: assert property (@(posedge clk) disable iff (!arst_n)
      (edge_en && !load && op_q != PBS_IDLE) |=> step_q == $past(step_q) + 2'h1)
      else $error("burst counter did not advance");
   a_load_clear: assert property (@(posedge clk) disable iff (!arst_n)
      (edge_en && load) |=> step_q == 2'h0 && base_q == $past(addr))
      else $error("load did not take address");
   a_dummy_read: assert property (@(posedge clk) disable iff (!arst_n)
      oe_n_s |-> data_oe == '0)
      else $error("bus driven with output enable high");
   a_idle_step: assert property (@(posedge clk) disable iff (!arst_n)
      (edge_en && !load && op_q == PBS_IDLE) |=> p_op_q[0] == PBS_IDLE)
      else $error("step after deselect started transfer");
   a_abort_write: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_phase && p_we_q[1] == '0) |=> mem_q[$past(p_addr_q[1])] == $past(mem_q[p_addr_q[1]]))
      else $error("abort write changed storage");
   a_burst_dir: assert property (@(posedge clk) disable iff (!arst_n)
      (edge_en && !load && op_q != PBS_IDLE) |=> p_op_q[0] == $past(op_q))
      else $error("continue cycle lost burst direction");
   a_linear_step: assert property (@(posedge clk) disable iff (!arst_n)
      (edge_en && !load && op_q != PBS_IDLE && !interleaved)
      |=> p_addr_q[0][1:0] == $past(p_addr_q[0][1:0]) + 2'h1)
      else $error("linear burst address not incremented");
   a_interleave_step: assert property (@(posedge clk) disable iff (!arst_n)
      (edge_en && !load && op_q != PBS_IDLE && interleaved)
      |=> (p_addr_q[0][1:0] ^ base_q[1:0]) == step_q)
      else $error("interleaved burst address wrong");
   a_lane_kept: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_phase && !p_we_q[1][0])
      |=> mem_q[$past(p_addr_q[1])][`PBS_LANE_W-1:0] == $past(mem_q[p_addr_q[1]][`PBS_LANE_W-1:0]))
      else $error("disabled lane was written");
   a_lane_written: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_phase && p_we_q[1][0])
      |=> mem_q[$past(p_addr_q[1])][`PBS_LANE_W-1:0] == $past(data_in[`PBS_LANE_W-1:0]))
      else $error("enabled lane not written");
   a_ignore_pipe: assert property (@(posedge clk) disable iff (!arst_n)
      !edge_en |=> $stable(p_op_q[1]) && $stable(p_addr_q[1]) && $stable(p_we_q[1]))
      else $error("pipeline moved on ignored edge");
   a_snooze_freeze: assert property (@(posedge clk) disable iff (!arst_n)
      snooze_s |=> $stable(op_q) && $stable(step_q) && $stable(base_q))
      else $error("burst state changed while snoozing");
   a_deselect_idle: assert property (@(posedge clk) disable iff (!arst_n)
      (edge_en && load && !selected) |=> op_q == PBS_IDLE)
      else $error("deselect did not stop burst");
endmodule // pbs_sram_port
`default_nettype wire

// ### sim/pbs_host.sv
// Host controller model for the burst SRAM port
`timescale 1ns/1ps
`default_nettype none
`include "pbs_consts.svh"
module pbs_host (
   input  wire logic                   clk,
   output var  logic                   clk_en_n,
   output var  logic                   chip_select_n,
   output var  logic                   chip_select2_n,
   output var  logic                   chip_select_high,
   output var  logic                   burst_step_or_load,
   output var  logic                   read_not_write,
   output var  logic [`PBS_ADDR_W-1:0] addr,
   output var  logic [`PBS_LANES-1:0]  lane_write_n,
   output var  logic [`PBS_DATA_W-1:0] data_in
);
   logic [`PBS_DATA_W-1:0] pend0 = '0;
   logic [`PBS_DATA_W-1:0] pend1 = '0;
   initial begin
      {clk_en_n, burst_step_or_load, chip_select_high} = 3'h0;
      {chip_select_n, chip_select2_n, read_not_write} = 3'h7;
      addr = '0;
      lane_write_n = '1;
      data_in = '0;
   end
   ////////////////////////////////////////////////////////////
   // Write data trails its control by two enabled edges
   task automatic cyc(input logic c, l, input logic [2:0] s, input logic r,
                      input logic [17:0] a, input logic [3:0] b, input logic [`PBS_DATA_W-1:0] wd);
      @(posedge clk);
      clk_en_n <= c;
      burst_step_or_load <= l;
      {chip_select_high, chip_select2_n, chip_select_n} <= s ^ 3'h3;
      read_not_write <= r;
      addr <= a;
      lane_write_n <= b;
      if (!c) begin
         data_in <= pend1;
         pend1 = pend0;
         pend0 = wd;
      end
   endtask
endmodule // pbs_host
`default_nettype wire

// ### sim/pbs_sram_port_tb_top.sv
// Self-checking bench for the burst SRAM port
`timescale 1ns/1ps
`default_nettype none
`include "pbs_consts.svh"
module pbs_sram_port_tb_top;
   logic                   clk = 1'b0;
   logic                   arst_n = 1'b0;
   logic                   oe_n = 1'b0;
   logic                   order = 1'b1;
   logic                   snooze = 1'b0;
   logic                   cen, cs_n, cs2_n, cs_h, ld, rnw, snoozing, act, dir, pc;
   logic [17:0]            addr;
   logic [3:0]             bw_n;
   logic [`PBS_DATA_W-1:0] din, dout, doe;
   logic [`PBS_DATA_W-1:0] mem [256];
   logic [`PBS_DATA_W:0]   expq [$];
   logic [`PBS_DATA_W:0]   last = '0;
   logic [7:0]             st;
   logic [1:0]             k;
   int                     n_mismatch = 0;
   int                     samples_checked = 0;
   int                     wcnt = 0;
   initial begin
      forever #20 clk = ~clk;
   end
   pbs_host i_pbs_host (.clk(clk), .clk_en_n(cen), .chip_select_n(cs_n), .chip_select2_n(cs2_n),
      .chip_select_high(cs_h), .burst_step_or_load(ld), .read_not_write(rnw), .addr(addr),
      .lane_write_n(bw_n), .data_in(din));
   pbs_sram_port i_pbs_sram_port (.clk(clk), .arst_n(arst_n), .clk_en_n(cen), .chip_select_n(cs_n),
      .chip_select2_n(cs2_n), .chip_select_high(cs_h), .burst_step_or_load(ld), .read_not_write(rnw),
      .addr(addr), .lane_write_n(bw_n), .out_enable_n(oe_n), .burst_order(order),
      .snooze_request(snooze), .data_in(din), .data_out(dout), .data_oe(doe), .snoozing(snoozing));
   ////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   // One cycle; compares the output due from two enabled edges back
   task automatic go(input logic c, l, input logic [2:0] s, input logic r, input logic [17:0] a,
                     input logic [3:0] b);
      logic [`PBS_DATA_W-1:0] wd;
      logic [7:0]             ad;
      logic [`PBS_DATA_W:0]   e;
      wcnt++;
      wd = {4{wcnt[8:0]}} ^ 36'h9_3c5a_a5c3;
      i_pbs_host.cyc(c, l, s, r, a, b, wd);
      #1;
      if (pc) begin
         check(doe === {36{last[36]}} && (!last[36] || dout === last[35:0]), "output moved");
      end else if (expq.size() > 2) begin
         last = expq.pop_front();
         check(doe === {36{last[36]}} && (!last[36] || dout === last[35:0]), "read data");
      end
      pc = c;
      if (!c) begin
         if (!l) begin
            act = (s == 3'h7);
            dir = r;
            st = a[7:0];
            k = 2'h0;
         end else begin
            k = k + 2'h1;
         end
         ad = {st[7:2], order ? st[1:0] ^ k : st[1:0] + k};
         e = '0;
         if (act && dir) begin
            e = {!oe_n, mem[ad]};
         end
         for (int i = 0; i < 4; i++) begin
            if (act && !dir && !b[i]) begin
               mem[ad][i*9+:9] = wd[i*9+:9];
            end
         end
         expq.push_back(e);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) go(1'b0, 1'b0, 3'h0, 1'b1, 18'h0, 4'hf);
   endtask
   task automatic reset_dut(input logic o);
      arst_n <= 1'b0;
      order <= o;
      repeat (6) @(posedge clk);
      #1;
      check(doe === '0, "driven in reset");
      arst_n <= 1'b1;
      expq.delete();
      act = 1'b0;
      pc = 1'b0;
      foreach (mem[i]) mem[i] = '0;
      repeat (5) @(posedge clk);
      #1;
      check(doe === '0, "driven before cycles");
   endtask
   // Write burst with lane mixes and a wrap, then read back at once
   task automatic s_burst;
      go(1'b0, 1'b0, 3'h7, 1'b0, 18'h0000d, 4'h0);
      go(1'b0, 1'b1, 3'h0, 1'b1, 18'h3ffff, 4'h6);
      go(1'b0, 1'b1, 3'h0, 1'b1, 18'h3ffff, 4'he);
      go(1'b0, 1'b1, 3'h0, 1'b1, 18'h3ffff, 4'hf);
      go(1'b0, 1'b1, 3'h0, 1'b1, 18'h3ffff, 4'h9);
      go(1'b0, 1'b0, 3'h7, 1'b1, 18'h0000d, 4'hf);
      repeat (4) go(1'b0, 1'b1, 3'h0, 1'b0, 18'h00020, 4'h0);
      idle(3);
   endtask
   task automatic s_hold;
      go(1'b0, 1'b0, 3'h7, 1'b1, 18'h0000e, 4'hf);
      repeat (2) go(1'b1, 1'b1, 3'h0, 1'b1, 18'h0, 4'hf);
      go(1'b0, 1'b1, 3'h0, 1'b1, 18'h0, 4'hf);
      go(1'b1, 1'b1, 3'h0, 1'b1, 18'h0, 4'hf);
      repeat (2) go(1'b0, 1'b1, 3'h0, 1'b1, 18'h0, 4'hf);
      idle(3);
   endtask
   task automatic s_desel;
      go(1'b0, 1'b0, 3'h7, 1'b1, 18'h0000d, 4'hf);
      for (int i = 0; i < 3; i++) begin
         go(1'b0, 1'b0, 3'h7 ^ (3'h1 << i), 1'b1, 18'h0000d, 4'hf);
         go(1'b0, 1'b1, 3'h7, 1'b1, 18'h0000d, 4'hf);
      end
      idle(3);
   endtask
   task automatic s_dummy;
      oe_n <= 1'b1;
      idle(6);
      go(1'b0, 1'b0, 3'h7, 1'b1, 18'h0000d, 4'hf);
      repeat (3) go(1'b0, 1'b1, 3'h0, 1'b1, 18'h0, 4'hf);
      // Enable returns mid-burst; sync latency meets the data phase
      oe_n <= 1'b0;
      repeat (4) go(1'b0, 1'b1, 3'h0, 1'b1, 18'h0, 4'hf);
      idle(3);
   endtask
   task automatic wait_snz(input logic v);
      for (int i = 0; i < 12 && snoozing !== v; i++) begin
         @(posedge clk);
         #1;
      end
      check(snoozing === v, "snooze state");
      if (snoozing !== v) summarize();
   endtask
   task automatic s_snooze;
      idle(2);
      @(posedge clk);
      snooze <= 1'b1;
      wait_snz(1'b1);
      @(posedge clk);
      snooze <= 1'b0;
      wait_snz(1'b0);
   endtask
   initial begin
      reset_dut(1'b1);
      s_burst();
      s_hold();
      s_desel();
      s_dummy();
      reset_dut(1'b0);
      s_burst();
      s_snooze();
      summarize();
   end
endmodule // pbs_sram_port_tb_top
`default_nettype wire
